// ===== core/cdrp_dma_port.sv
// codec dma request and acknowledge logic with sample countdown
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "cdrp_defs.svh"

module cdrp_dma_port #(
    parameter int unsigned INIT_CYCLES = (`CDRP_CLK_HZ / 1000) * `CDRP_INIT_MS
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic             clkEn,
    // register port
    input  wire logic [3:0]       regAddr,
    input  wire logic [7:0]       regWrData,
    input  wire logic             regWr,
    input  wire logic             regRd,
    output logic      [7:0]       regRdData,
    // hardware power pins
    input  wire logic             powerOffNPin,
    input  wire logic             resetNPin,
    // format and sample sources
    input  wire cdrp_pkg::cdrp_fmt_t dataFormat,
    input  wire logic             playNeed,
    input  wire logic             captureReady,
    input  wire logic [7:0]       captureByte,
    // host dma pins
    input  wire logic             captureAckN,
    input  wire logic             playbackAckN,
    input  wire logic             hostRdN,
    input  wire logic             hostWrN,
    input  wire logic             chipSelN,
    input  wire logic [1:0]       indexAddrLines,
    input  wire logic [7:0]       dataIn,
    output logic      [7:0]       dataOut,
    output logic                  dataOe,
    output logic                  captureRequestLine,
    output logic                  playbackRequestLine,
    output logic                  irqPin,
    output logic      [7:0]       playByte,
    output logic                  playByteValid,
    output logic                  captureByteTaken
);
    import cdrp_pkg::*;

    localparam int unsigned INIT_W = $clog2(INIT_CYCLES + 1);

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rstSync1, rstnSync;

    // two-stage release of the async reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstSync1 <= 1'b0;
            rstnSync <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstnSync <= rstSync1;
        end
    end

    // ---------------------------------------------------------------
    // state and registers
    // ---------------------------------------------------------------
    cdrp_state_t      state_r;
    logic [INIT_W-1:0] initCnt_r;
    logic [7:0]       ctrl_r;
    logic [7:0]       baseLo_r, baseHi_r;
    logic [2:0]       clkSel_r;
    logic [15:0]      curCount_r;
    logic             irqFlag_r;
    logic [1:0]       byteCnt_r;
    logic             busyDir_r;      // 1 = last acked byte was capture
    logic             inSample_r;
    logic             ackSeen_r;
    logic             strobePrev_r;
    logic             shareCap_r;     // shared channel carries capture

    wire pinsUp   = powerOffNPin & resetNPin;
    wire running  = (state_r == CDRP_ST_RUN);
    wire playback_enable      = ctrl_r[`CDRP_CTL_PEN];
    wire capture_enable      = ctrl_r[`CDRP_CTL_CEN];
    wire single_channel_sel      = ctrl_r[`CDRP_CTL_SDC];
    wire playDma  = playback_enable & ~ctrl_r[`CDRP_CTL_PLAYBACK_POLLED_IO];
    wire capDma   = capture_enable & ~ctrl_r[`CDRP_CTL_CAPTURE_POLLED_IO];
    // single channel direction, playback wins when both set
    wire sdcCapNow = single_channel_sel & capDma & ~playback_enable;
    // direction frozen from request to sample end, so an abort still finishes
    wire shareHeld = playbackRequestLine | inSample_r;
    wire sdcCap    = shareHeld ? shareCap_r : sdcCapNow;
    // effective acknowledges; capture ack ignored in single mode
    wire capAck   = single_channel_sel ? (~playbackAckN & sdcCap) : ~captureAckN;
    wire playAck  = ~playbackAckN & ~(single_channel_sel & sdcCap);
    wire anyAck   = running & (capAck | playAck);
    wire strobe   = ~hostRdN | ~hostWrN;
    wire strobeFall = strobe & ~strobePrev_r;
    logic [1:0] lastByte;

    // bytes per sample from the format
    always_comb begin
        case (dataFormat)
            CDRP_FMT_8M:  lastByte = 2'd0;
            CDRP_FMT_8S:  lastByte = 2'd1;
            CDRP_FMT_16M: lastByte = 2'd1;
            default:      lastByte = 2'd3;
        endcase
    end

    wire sampleEnd = anyAck & strobeFall & (byteCnt_r == lastByte);

    // shared channel direction, held while a request or sample is open
    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            shareCap_r <= 1'b0;
        end else if (clkEn) begin
            shareCap_r <= sdcCap;
        end
    end

    // init sequencer; power pins low hold the block off
    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            state_r   <= CDRP_ST_OFF;
            initCnt_r <= '0;
        end else if (clkEn) begin
            if (!pinsUp) begin
                state_r   <= CDRP_ST_OFF;
                initCnt_r <= '0;
            end else begin
                case (state_r)
                    CDRP_ST_OFF: state_r <= CDRP_ST_INIT;
                    CDRP_ST_INIT: begin
                        if (initCnt_r == INIT_W'(INIT_CYCLES - 1)) begin
                            state_r <= CDRP_ST_RUN;
                        end else begin
                            initCnt_r <= initCnt_r + 1'b1;
                        end
                    end
                    CDRP_ST_RUN: state_r <= CDRP_ST_RUN;
                    default:     state_r <= CDRP_ST_OFF;
                endcase
            end
        end
    end

    wire wrOk = running & regWr;

    // control and clock select; defaults on each init
    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            ctrl_r   <= `CDRP_CTRL_RST;
            clkSel_r <= 3'h0;
        end else if (clkEn) begin
            if (!running) begin
                ctrl_r   <= `CDRP_CTRL_RST;
                clkSel_r <= 3'h0;
            end else if (wrOk && regAddr == `CDRP_REG_CTRL) begin
                ctrl_r <= regWrData;
            end else if (wrOk && regAddr == `CDRP_REG_CLKSEL
                         && ctrl_r[`CDRP_CTL_MCE] && ctrl_r[`CDRP_CTL_EXTENDED_MODE_SEL]) begin
                clkSel_r <= regWrData[2:0];
            end
        end
    end

    // base bytes, counter and interrupt
    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            baseLo_r   <= 8'h00;
            baseHi_r   <= 8'h00;
            curCount_r <= 16'h0000;
            irqFlag_r  <= 1'b0;
        end else if (clkEn) begin
            if (!running) begin
                baseLo_r   <= 8'h00;
                baseHi_r   <= 8'h00;
                curCount_r <= 16'h0000;
                irqFlag_r  <= 1'b0;
            end else begin
                if (wrOk && regAddr == `CDRP_REG_BASE_LO) begin
                    baseLo_r <= regWrData;
                end
                if (wrOk && regAddr == `CDRP_REG_BASE_HI) begin
                    baseHi_r   <= regWrData;
                    curCount_r <= {regWrData, baseLo_r};
                end else if (sampleEnd) begin
                    curCount_r <= curCount_r - 16'h0001;
                end
                // set wins over a software clear of the flag
                if (sampleEnd && curCount_r == 16'h0000) begin
                    irqFlag_r <= 1'b1;
                end else if (wrOk && regAddr == `CDRP_REG_STATUS) begin
                    irqFlag_r <= 1'b0;
                end
            end
        end
    end

    // byte sequencing within a sample, low byte first
    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            byteCnt_r    <= 2'd0;
            strobePrev_r <= 1'b0;
            busyDir_r    <= 1'b0;
            inSample_r   <= 1'b0;
        end else if (clkEn) begin
            strobePrev_r <= strobe;
            if (!running) begin
                byteCnt_r  <= 2'd0;
                inSample_r <= 1'b0;
            end else if (anyAck && strobeFall) begin
                inSample_r <= ~sampleEnd;
                busyDir_r  <= capAck;
                byteCnt_r  <= sampleEnd ? 2'd0 : byteCnt_r + 2'd1;
            end
        end
    end

    // request lines: hold until whole sample done
    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            captureRequestLine  <= 1'b0;
            playbackRequestLine <= 1'b0;
            ackSeen_r           <= 1'b0;
        end else if (clkEn) begin
            ackSeen_r <= anyAck;
            if (!running) begin
                captureRequestLine  <= 1'b0;
                playbackRequestLine <= 1'b0;
            end else if (sampleEnd) begin
                captureRequestLine  <= 1'b0;
                playbackRequestLine <= 1'b0;
            end else begin
                // raise when enabled; a raised line stays up even after abort
                if (!single_channel_sel && capDma && captureReady) begin
                    captureRequestLine <= 1'b1;
                end else if (single_channel_sel) begin
                    captureRequestLine <= 1'b0;
                end
                if ((single_channel_sel ? (sdcCap ? captureReady : playDma & playNeed)
                         : playDma & playNeed)) begin
                    playbackRequestLine <= 1'b1;
                end
            end
        end
    end

    // data path: ack alone selects the sample register
    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            dataOut          <= 8'h00;
            dataOe           <= 1'b0;
            playByte         <= 8'h00;
            playByteValid    <= 1'b0;
            captureByteTaken <= 1'b0;
        end else if (clkEn) begin
            playByteValid    <= 1'b0;
            captureByteTaken <= 1'b0;
            if (!pinsUp) begin
                dataOe <= 1'b0;
            end else if (anyAck && capAck && !hostRdN) begin
                dataOut <= captureByte;
                dataOe  <= 1'b1;
                if (strobeFall) begin
                    captureByteTaken <= 1'b1;
                end
            end else begin
                dataOe <= 1'b0;
                if (anyAck && playAck && !hostWrN && strobeFall) begin
                    playByte      <= dataIn;
                    playByteValid <= 1'b1;
                end
            end
        end
    end

    // register readback and interrupt pin
    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            regRdData <= 8'h00;
            irqPin    <= 1'b0;
        end else if (clkEn) begin
            irqPin <= irqFlag_r & ctrl_r[`CDRP_CTL_IEN];
            if (!regRd) begin
                regRdData <= 8'h00;
            end else if (!running) begin
                regRdData <= `CDRP_BUSY_VALUE;
            end else begin
                case (regAddr)
                    `CDRP_REG_CTRL:    regRdData <= ctrl_r;
                    `CDRP_REG_STATUS:  regRdData <= {6'h00, inSample_r, irqFlag_r};
                    `CDRP_REG_BASE_LO: regRdData <= baseLo_r;
                    `CDRP_REG_BASE_HI: regRdData <= baseHi_r;
                    `CDRP_REG_INDEX:   regRdData <= {6'h00, busyDir_r, ackSeen_r};
                    `CDRP_REG_CLKSEL:  regRdData <= {5'h00, clkSel_r};
                    default:           regRdData <= 8'h00;
                endcase
            end
        end
    end

    // chip select and index lines play no part in dma
    wire unusedPins = chipSelN ^ ^indexAddrLines;
endmodule : cdrp_dma_port

// ===== core/cdrp_defs.svh
// constants for the codec dma request port
// ---------------------------------------------------------------
// Overview of operation
// - playback dma runs only with playback enabled and polled io off
// - capture dma runs only with capture enabled and polled io off
// - device raises request, host answers with low ack, byte moves
// - acked cycles ignore index address and use direction sample register
// - dma bytes delimited by strobes alone, chip select ignored
// - request may rise anytime, then holds until acked cycle
// - request drops after last strobe falling edge of a whole sample
// - clearing an enable aborts that direction, capture sample finishes; code also finishes an open playback sample
// - single channel mode carries both directions on playback pair
// - single mode: capture request low, capture ack ignored
// - single mode direction follows enables, both set means playback
// - enable changes accepted anytime without mode change state
// - writing upper base count loads the 16-bit current counter
// - current counter unreadable, base bytes read back as written
// - counter decrements per sample, interrupt set on underflow
// - status flag mirrors interrupt, pin high only when enabled
// - init after both pins high, about 512 ms, writes ignored, reads 80h
// - after init registers take defaults and mode change state is set
// - clock select: extended mode, mode change, write, poll, clear
// - power-off or reset pin low stops interface and floats data
// - samples move low byte first, left before right
// ---------------------------------------------------------------
`ifndef CDRP_DEFS_SVH
`define CDRP_DEFS_SVH

// register offsets
`define CDRP_REG_CTRL     4'h0
`define CDRP_REG_STATUS   4'h1
`define CDRP_REG_BASE_LO  4'h2
`define CDRP_REG_BASE_HI  4'h3
`define CDRP_REG_INDEX    4'h4
`define CDRP_REG_CLKSEL   4'h5

// control field positions
`define CDRP_CTL_PEN      0
`define CDRP_CTL_CEN      1
`define CDRP_CTL_PLAYBACK_POLLED_IO     2
`define CDRP_CTL_CAPTURE_POLLED_IO     3
`define CDRP_CTL_SDC      4
`define CDRP_CTL_IEN      5
`define CDRP_CTL_MCE      6
`define CDRP_CTL_EXTENDED_MODE_SEL    7

// reset values
`define CDRP_CTRL_RST     8'h40
`define CDRP_BUSY_VALUE   8'h80
`define CDRP_FMT_RST      2'h0

// timing
`define CDRP_INIT_MS      512
`define CDRP_CLK_HZ       50000000

`endif

// ===== core/cdrp_pkg.sv
// types for the codec dma request port
package cdrp_pkg;
    typedef enum logic [1:0] {
        CDRP_FMT_8M  = 2'b00,
        CDRP_FMT_8S  = 2'b01,
        CDRP_FMT_16M = 2'b10,
        CDRP_FMT_16S = 2'b11
    } cdrp_fmt_t;

    typedef enum logic [1:0] {
        CDRP_ST_OFF  = 2'b00,
        CDRP_ST_INIT = 2'b01,
        CDRP_ST_RUN  = 2'b10
    } cdrp_state_t;
endpackage : cdrp_pkg

// ===== tb/cdrp_dma_port_chk.sv
// concurrent checks on the dma request port pins
`timescale 1ns/1ps
`include "cdrp_defs.svh"
module cdrp_dma_port_chk (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdData,
    input wire logic       powerOffNPin,
    input wire logic       resetNPin,
    input wire logic       hostRdN,
    input wire logic       hostWrN,
    input wire logic       dataOe,
    input wire logic       captureRequestLine,
    input wire logic       playbackRequestLine,
    input wire logic       irqPin,
    input wire logic       playByteValid,
    input wire logic       captureByteTaken
);
    logic [7:0] ctl_r;
    logic       pinsOn;
    // ----
    // control shadow, back to defaults while a pin holds the part off
    // ----
    assign pinsOn = powerOffNPin && resetNPin;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) ctl_r <= `CDRP_CTRL_RST;
        else if (!pinsOn) ctl_r <= `CDRP_CTRL_RST;
        else if (regWr && regAddr == `CDRP_REG_CTRL) ctl_r <= regWrData;
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_rdIdle; !$past(regRd) |-> regRdData == 8'h00; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
    property p_capSingle; ctl_r[4] && $past(ctl_r[4]) |-> !captureRequestLine; endproperty
    a_capSingle: assert property (p_capSingle) else $error("capture line in single");
    property p_irqGate; !ctl_r[5] && !$past(ctl_r[5]) |-> !irqPin; endproperty
    a_irqGate: assert property (p_irqGate) else $error("irq pin while masked");
    property p_playRose;
        $rose(playbackRequestLine) |->
            $past(ctl_r[0] && !ctl_r[2] || ctl_r[4] && ctl_r[1] && !ctl_r[3]);
    endproperty
    a_playRose: assert property (p_playRose) else $error("playback request not enabled");
    property p_capRose; $rose(captureRequestLine) |-> $past(ctl_r[1] && !ctl_r[3]); endproperty
    a_capRose: assert property (p_capRose) else $error("capture request not enabled");
    property p_reqHold;
        playbackRequestLine && hostRdN && hostWrN && pinsOn |=> playbackRequestLine;
    endproperty
    a_reqHold: assert property (p_reqHold) else $error("request dropped unserved");
    property p_playValid; playByteValid |-> $past(!hostWrN) && $past(hostWrN, 2); endproperty
    a_playValid: assert property (p_playValid) else $error("byte without strobe");
    property p_capTaken; captureByteTaken |-> $past(!hostRdN) && $past(hostRdN, 2); endproperty
    a_capTaken: assert property (p_capTaken) else $error("read without strobe");
    property p_oeOff;
        !pinsOn && $past(!pinsOn) && $past(!pinsOn, 2) |-> !dataOe && !playbackRequestLine;
    endproperty
    a_oeOff: assert property (p_oeOff) else $error("driving while off");
endmodule : cdrp_dma_port_chk

bind cdrp_dma_port cdrp_dma_port_chk u_chk (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .powerOffNPin(powerOffNPin), .resetNPin(resetNPin), .hostRdN(hostRdN), .hostWrN(hostWrN),
    .dataOe(dataOe), .captureRequestLine(captureRequestLine),
    .playbackRequestLine(playbackRequestLine), .irqPin(irqPin),
    .playByteValid(playByteValid), .captureByteTaken(captureByteTaken));

// ===== tb/cdrp_host_dma.sv
// host dma controller model driving acks, strobes and write data
`timescale 1ns/1ps
module cdrp_host_dma (
    input  wire logic       sys_clk,
    input  wire logic       playReq,
    input  wire logic       capReq,
    input  wire logic       capOnPlay,
    input  wire logic [2:0] nBytes,
    input  wire logic [3:0] lag,
    output logic            playAckN,
    output logic            capAckN,
    output logic            rdN,
    output logic            wrN,
    output logic [7:0]      wrData
);
    logic [7:0] seq;
    logic       onPlay;
    logic       isRd;
    // one whole sample per request, answering after lag cycles
    initial begin
        {playAckN, capAckN, rdN, wrN} = 4'hF;
        wrData = 8'h5A;
        seq = 8'h00;
        forever begin
            @(posedge sys_clk);
            if (playReq || capReq) begin
                onPlay = playReq;
                isRd = onPlay ? capOnPlay : 1'b1;
                repeat (lag) @(posedge sys_clk);
                playAckN <= !onPlay;
                capAckN <= onPlay;
                // sample finished even if aborted meanwhile
                for (int i = 0; i < nBytes; i++) begin
                    if (!isRd) wrData <= seq;
                    @(posedge sys_clk);
                    if (isRd) rdN <= 1'b0;
                    else wrN <= 1'b0;
                    repeat (2) @(posedge sys_clk);
                    {rdN, wrN} <= 2'b11;
                    wrData <= ~seq; // released bus shows no stale byte
                    if (!isRd) seq <= seq + 8'h01;
                    @(posedge sys_clk);
                end
                {playAckN, capAckN} <= 2'b11;
            end
        end
    end
endmodule : cdrp_host_dma

// ===== tb/codec_dma_request_port_test.sv
// self-checking bench for the dma request port
`timescale 1ns/1ps
`include "cdrp_defs.svh"
module codec_dma_request_port_test;
    import cdrp_pkg::*;
    logic sys_clk = 0, rstn = 0, regWr = 0, regRd = 0, pOffN = 0, rstPinN = 1'b1;
    logic playNeed = 0, capRdy = 0, capOnPlay = 0, csN = 1'b1, oe, cReq, pReq, irq;
    logic rdN, wrN, cAckN, pAckN, pValid, cTaken;
    logic [3:0] regAddr = 0, lag = 0;
    logic [7:0] regWrData = 0, capByte = 0, rdData, dIn, dOut, pByte, expPlay = 0, v;
    logic [1:0] idx = 0;
    logic [2:0] nBytes = 3'd1;
    cdrp_fmt_t  fmt = CDRP_FMT_8M;
    int numErrors = 0, cmpCount = 0, nPlay = 0, nCap = 0, n0, c0;
    always #10 sys_clk = ~sys_clk;
    cdrp_dma_port #(.INIT_CYCLES(16)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .clkEn(1'b1),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(rdData), .powerOffNPin(pOffN), .resetNPin(rstPinN), .dataFormat(fmt),
        .playNeed(playNeed), .captureReady(capRdy), .captureByte(capByte),
        .captureAckN(cAckN), .playbackAckN(pAckN), .hostRdN(rdN), .hostWrN(wrN),
        .chipSelN(csN), .indexAddrLines(idx), .dataIn(dIn), .dataOut(dOut), .dataOe(oe),
        .captureRequestLine(cReq), .playbackRequestLine(pReq), .irqPin(irq),
        .playByte(pByte), .playByteValid(pValid), .captureByteTaken(cTaken));
    cdrp_host_dma u_host (.sys_clk(sys_clk), .playReq(pReq), .capReq(cReq),
        .capOnPlay(capOnPlay), .nBytes(nBytes), .lag(lag), .playAckN(pAckN),
        .capAckN(cAckN), .rdN(rdN), .wrN(wrN), .wrData(dIn));
    function automatic logic [2:0] fmtBytes(input int f);
        return (f == 0) ? 3'd1 : (f == 3) ? 3'd4 : 3'd2;
    endfunction : fmtBytes
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        cmpCount++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d = rdData;
    endtask : rd
    task automatic waitInit;
        v = `CDRP_BUSY_VALUE;
        for (int k = 0; k < 60 && v === 8'h80; k++) rd(`CDRP_REG_INDEX, v);
        check({7'h0, v === 8'h80}, 8'h00, "init end");
    endtask : waitInit
    task automatic waitCnt(input int target, input bit cap);
        for (int k = 0; k < 900 && (cap ? nCap : nPlay) < target; k++) @(posedge sys_clk);
    endtask : waitCnt
    task automatic tallyAndFinish;
        if (numErrors == 0 && cmpCount > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tallyAndFinish
    // byte monitor, strobe-only addressing noise
    always @(posedge sys_clk) begin
        if (pValid === 1'b1) begin
            check(pByte, expPlay, "playByte");
            expPlay = expPlay + 8'h01;
            nPlay++;
        end
        if (cTaken === 1'b1) begin
            check(dOut, capByte, "dataOut");
            nCap++;
        end
        csN <= 1'($urandom);
        idx <= 2'($urandom);
    end
    initial begin
        #(20ns * 30000);
        numErrors++;
        tallyAndFinish;
    end
    initial begin
        void'($urandom(15));
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        pOffN <= 1'b1;
        repeat (2) @(posedge sys_clk); // reset release ripples through two flops
        rd(`CDRP_REG_INDEX, v);
        check(v, `CDRP_BUSY_VALUE, "busy read");
        wr(`CDRP_REG_BASE_LO, 8'hA5);
        waitInit;
        rd(`CDRP_REG_BASE_LO, v);
        check(v, 8'h00, "ignored write");
        rd(`CDRP_REG_CTRL, v);
        check(v, `CDRP_CTRL_RST, "ctrl default");
        rd(4'hF, v);
        check(v, 8'h00, "unmapped");
        c0 = $urandom;
        wr(`CDRP_REG_BASE_LO, c0[7:0]);
        wr(`CDRP_REG_BASE_HI, c0[15:8]);
        rd(`CDRP_REG_BASE_LO, v);
        check(v, c0[7:0], "base lo");
        rd(`CDRP_REG_BASE_HI, v);
        check(v, c0[15:8], "base hi");
        wr(`CDRP_REG_CLKSEL, 8'h05);
        rd(`CDRP_REG_CLKSEL, v);
        check(v, 8'h00, "clock select locked");
        wr(`CDRP_REG_CTRL, 8'hC0);
        wr(`CDRP_REG_CLKSEL, 8'h03);
        waitInit;
        rd(`CDRP_REG_CLKSEL, v);
        check(v, 8'h03, "clock select");
        playNeed <= 1'b1;
        capRdy <= 1'b1;
        wr(`CDRP_REG_CTRL, 8'h0F);
        repeat (60) @(posedge sys_clk);
        check(8'(nPlay + nCap), 8'h00, "polled io");
        capRdy <= 1'b0;
        for (int f = 0; f < 4; f++) begin
            fmt <= cdrp_fmt_t'(f);
            nBytes <= fmtBytes(f);
            lag <= 4'($urandom_range(0, 6));
            wr(`CDRP_REG_STATUS, 8'h00);
            wr(`CDRP_REG_BASE_LO, 8'h01);
            wr(`CDRP_REG_BASE_HI, 8'h00);
            n0 = nPlay;
            wr(`CDRP_REG_CTRL, 8'h21);
            waitCnt(n0 + fmtBytes(f), 0);
            rd(`CDRP_REG_STATUS, v);
            check(v & 8'h01, 8'h00, "early irq");
            waitCnt(n0 + 2 * fmtBytes(f), 0);
            wr(`CDRP_REG_CTRL, 8'h20);
            rd(`CDRP_REG_STATUS, v);
            check(v & 8'h01, 8'h01, "underflow");
            check({7'h0, irq}, 8'h01, "irq pin");
            for (int k = 0; k < 200 && pReq; k++) @(posedge sys_clk);
            repeat (30) @(posedge sys_clk);
            check(8'((nPlay - n0) % fmtBytes(f)), 8'h00, "whole samples");
            wr(`CDRP_REG_STATUS, 8'h00);
            repeat (2) @(posedge sys_clk);
            check({7'h0, irq}, 8'h00, "irq cleared");
        end
        for (int s = 0; s < 3; s++) begin
            capOnPlay <= (s == 1);
            capRdy <= 1'b1;
            capByte <= 8'($urandom);
            c0 = nCap;
            n0 = nPlay;
            wr(`CDRP_REG_CTRL, s == 0 ? 8'h02 : s == 1 ? 8'h12 : 8'h13);
            waitCnt((s == 2) ? n0 + 8 : c0 + 8, s != 2);
            wr(`CDRP_REG_CTRL, s == 0 ? 8'h00 : 8'h10);
            for (int k = 0; k < 200 && (pReq || cReq); k++) @(posedge sys_clk);
            repeat (30) @(posedge sys_clk);
            if (s == 2) check(8'(nCap - c0), 8'h00, "shared as playback");
            else check(8'((nCap - c0) % nBytes), 8'h00, "capture sample");
        end
        for (int p = 0; p < 2; p++) begin
            c0 = nCap;
            capOnPlay <= 1'b0;
            wr(`CDRP_REG_CTRL, 8'h02);
            waitCnt(c0 + 1, 1);
            if (p == 0) pOffN <= 1'b0;
            else rstPinN <= 1'b0;
            repeat (6) @(posedge sys_clk);
            check({6'h0, oe, cReq}, 8'h00, "pins off");
            pOffN <= 1'b1;
            rstPinN <= 1'b1;
            rd(`CDRP_REG_INDEX, v);
            check(v, `CDRP_BUSY_VALUE, "restart busy");
            waitInit;
            rd(`CDRP_REG_CTRL, v);
            check(v, `CDRP_CTRL_RST, "ctrl default");
        end
        tallyAndFinish;
    end
endmodule : codec_dma_request_port_test
